// [pkg/smps_ctrl_defs.vh]
`ifndef SMPS_CTRL_DEFS_VH
`define SMPS_CTRL_DEFS_VH

`define CONV_COUNT       5
`define CODE_W           7

`define ADDR_W           12
`define OFF_GLOBAL_CTRL  12'h000
`define OFF_MASK_A       12'h004
`define OFF_MASK_B       12'h008
`define OFF_SLEEP_MAP    12'h00C
`define OFF_EN1_MAP      12'h010
`define OFF_STATUS       12'h014
`define OFF_EN2_MAP      12'h018
`define OFF_CONV_BASE    12'h020
`define CONV_STRIDE      12'h010
`define SUB_CTRL         2'h0
`define SUB_PRIMARY      2'h1
`define SUB_SECONDARY    2'h2
`define SUB_STATE        2'h3

`define RST_MASK_A       5'h1E
`define RST_MASK_B       2'h0
`define RST_MAP          5'h00
`define RST_GLOBAL       3'h0
`define RST_CTRL         2'h0
`define RST_VOLT         8'h00

`define BIT_CTRL_EN      0
`define BIT_CTRL_RF      1
`define BIT_RANGE        7
`define BIT_CMD          7
`define BIT_TYPE_SEL     0
`define BIT_ADC_MASK     1
`define BIT_COMPMODE     0
`define FLD_PHASE_HI     2
`define FLD_PHASE_LO     1

`define CLK_MHZ          250
`define SLEW_UV_PER_US   2500
`define CODE_STEP_UV     10000
`define STEP_CYCLES      (`CODE_STEP_UV * `CLK_MHZ / `SLEW_UV_PER_US)
`define STEP_CNT_W       10
// last count of the step divider, STEP_CYCLES - 1 at the counter width
`define STEP_LAST        10'h3E7

`endif

// [rtl/dvs_channel.v]
`timescale 1ns/1ps
`include "smps_ctrl_defs.vh"
module dvs_channel #(
	parameter SLEW = 1
) (
	input  wire                 pclk,
	input  wire                 presetn,
	input  wire                 step_tick,
	input  wire                 enable,
	input  wire                 roof_floor_en,
	input  wire                 pin_active,
	input  wire [7:0]           primary,
	input  wire [7:0]           secondary,
	output reg  [`CODE_W-1:0]   target,
	output reg  [`CODE_W-1:0]   present,
	output reg                  range_active,
	output reg                  on,
	output reg                  ramping
);
	wire                 use_primary;
	wire [`CODE_W-1:0]   sel_code;
	wire                 next_on;
	reg                  half;
	wire                 step_now;

	// pin level in roof-floor, command bit otherwise; cmd=0 is primary
	assign use_primary = roof_floor_en ? pin_active : ~secondary[`BIT_CMD]; // RULE_10 RULE_12
	assign sel_code    = use_primary ? primary[`CODE_W-1:0] : secondary[`CODE_W-1:0];
	// code zero is off in either register
	assign next_on     = enable & (sel_code != {`CODE_W{1'b0}}); // RULE_13 RULE_14
	// 20 mV codes step at half the rate to keep the same slew
	assign step_now    = step_tick & (~range_active | half);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target       <= {`CODE_W{1'b0}};
			present      <= {`CODE_W{1'b0}};
			range_active <= 1'b0;
			on           <= 1'b0;
			ramping      <= 1'b0;
			half         <= 1'b0;
		end else begin
			target <= sel_code; // RULE_21
			on     <= next_on;
			if (step_tick)
				half <= ~half;
			if (!on)
				range_active <= primary[`BIT_RANGE]; // RULE_19
			if (!on || !next_on || SLEW == 0) begin
				present <= sel_code; // RULE_15
				ramping <= 1'b0;
			end else begin
				ramping <= (present != sel_code); // RULE_04 RULE_21
				if (step_now && present < target)
					present <= present + 1'b1; // RULE_09
				else if (step_now && present > target)
					present <= present - 1'b1; // RULE_09
			end
		end
	end
endmodule

// [rtl/rail_ok_combiner.v]
`timescale 1ns/1ps
`include "smps_ctrl_defs.vh"
module rail_ok_combiner (
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire [`CONV_COUNT-1:0] vwin_ok,
	input  wire [`CONV_COUNT-1:0] ilim_ok,
	input  wire [`CONV_COUNT-1:0] ramping,
	input  wire [`CONV_COUNT-1:0] mask,
	input  wire                   dual_phase,
	input  wire                   current_only,
	input  wire                   compmode,
	input  wire                   adc_mask,
	input  wire                   adc_current_ok,
	output reg  [`CONV_COUNT-1:0] source_ok,
	output reg                    rail_ok
);
	wire [`CONV_COUNT-1:0] eff_mask;
	wire [`CONV_COUNT-1:0] good;
	wire                   adc_good;

	// second phase never a source of its own in dual phase
	assign eff_mask = mask | {{(`CONV_COUNT-2){1'b0}}, dual_phase, 1'b0}; // RULE_06
	// a ramping window result is forced good
	assign good = ilim_ok & (vwin_ok | ramping | {`CONV_COUNT{current_only}}); // RULE_01 RULE_02 RULE_04
	assign adc_good = ~compmode | adc_mask | adc_current_ok; // RULE_05

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_ok <= {`CONV_COUNT{1'b0}};
			rail_ok   <= 1'b0;
		end else begin
			source_ok <= good;
			rail_ok   <= (&(good | eff_mask)) & adc_good; // RULE_20
		end
	end
endmodule

// [rtl/smps_powergood_dvs_control.v]
// Function
// RULE_01 - rail good needs unmasked windows and currents
// RULE_02 - global select: voltage+current or current only
// RULE_03 - per-converter mask, only first unmasked
// RULE_04 - ramping converter window result suppressed
// RULE_05 - compare mode adds adc current result
// RULE_06 - dual phase: second source forced masked
// RULE_07 - software masks disabled converters
// RULE_08 - software masks pair or debounces
// RULE_09 - dvs converters slew 2.5 mV/us
// RULE_10 - roof-floor: pin active primary, else secondary
// RULE_11 - three pin maps assign converters
// RULE_12 - no roof-floor: command bit selects register
// RULE_13 - secondary code zero turns converter off
// RULE_14 - seven bit code, range bit scales
// RULE_15 - converters four and five jump
// RULE_16 - otp bit selects single or dual phase
// RULE_17 - phase field forces multi or single
// RULE_18 - software never forces multiphase unloaded
// RULE_19 - range frozen while converter on
// RULE_20 - registered and of unmasked goods
// RULE_21 - new code presented next cycle, ramp masked
`timescale 1ns/1ps
`include "smps_ctrl_defs.vh"
module smps_powergood_dvs_control (
	input  wire                          pclk,
	input  wire                          presetn,
	input  wire                          psel,
	input  wire                          penable,
	input  wire                          pwrite,
	input  wire [`ADDR_W-1:0]            paddr,
	input  wire [31:0]                   pwdata,
	output reg  [31:0]                   prdata,
	output reg                           pready,
	output reg                           pslverr,
	input  wire                          sleep_request_pin,
	input  wire                          enable_pin_one,
	input  wire                          enable_pin_two,
	input  wire                          dual_phase_otp,
	input  wire [`CONV_COUNT-1:0]        vwin_ok,
	input  wire [`CONV_COUNT-1:0]        ilim_ok,
	input  wire                          adc_current_ok,
	output wire                          rail_ok,
	output reg  [`CONV_COUNT*`CODE_W-1:0] conv_target,
	output reg  [`CONV_COUNT*`CODE_W-1:0] conv_code,
	output reg  [`CONV_COUNT-1:0]        conv_range,
	output reg  [`CONV_COUNT-1:0]        conv_on,
	output reg  [1:0]                    pair_phase_force,
	output reg                           dual_phase
);
	reg  [2:0]               global_ctrl;
	reg  [`CONV_COUNT-1:0]   rail_ok_source_mask_a;
	reg  [1:0]               rail_ok_source_mask_b;
	reg  [`CONV_COUNT-1:0]   sleep_pin_converter_map;
	reg  [`CONV_COUNT-1:0]   enable_one_converter_map;
	reg  [`CONV_COUNT-1:0]   enable_two_converter_map;
	reg  [1:0]               converter_control_reg [0:`CONV_COUNT-1];
	reg  [7:0]               primary_voltage_reg   [0:`CONV_COUNT-1];
	reg  [7:0]               secondary_voltage_reg [0:`CONV_COUNT-1];
	reg  [`STEP_CNT_W-1:0]   step_cnt;
	reg                      step_tick;
	reg  [31:0]              next_prdata;
	reg                      next_err;
	wire                     setup;
	wire                     wr_access;
	wire [`CONV_COUNT-1:0]   source_ok;
	wire [`CONV_COUNT-1:0]   ramping;
	wire [`CONV_COUNT-1:0]   ch_on;
	wire [`CONV_COUNT-1:0]   ch_range;
	wire [`CONV_COUNT*`CODE_W-1:0] ch_target;
	wire [`CONV_COUNT*`CODE_W-1:0] ch_code;
	wire [2:0]               conv_idx;
	wire [1:0]               conv_sub;
	wire                     conv_hit;

	// pin driven selection: any mapped pin that is high counts
	function pin_selects;
		input [`CONV_COUNT-1:0] smap;
		input [`CONV_COUNT-1:0] e1map;
		input [`CONV_COUNT-1:0] e2map;
		input [2:0]             idx;
		input                   s;
		input                   e1;
		input                   e2;
		begin
			pin_selects = (smap[idx] & s) | (e1map[idx] & e1) | (e2map[idx] & e2);
		end
	endfunction

	// converter window decode: 16 bytes per converter from the base
	function [2:0] conv_index;
		input [`ADDR_W-1:0] a;
		reg   [`ADDR_W-1:0] rel;
		begin
			rel        = a - `OFF_CONV_BASE;
			conv_index = rel[6:4];
		end
	endfunction

	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pready & pwrite & ~pslverr;
	assign conv_idx  = conv_index(paddr);
	assign conv_sub  = paddr[3:2];
	assign conv_hit  = (paddr >= `OFF_CONV_BASE) && (conv_idx < 3'd5) &&
		(paddr < `OFF_CONV_BASE + `CONV_COUNT * `CONV_STRIDE) && (paddr[1:0] == 2'b00);

	// apb: read data and error prepared in setup, access completes in one cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & next_err;
			if (setup && !pwrite)
				prdata <= next_prdata;
		end
	end

	always @* begin
		next_prdata = 32'h00000000;
		next_err    = 1'b0;
		if (paddr == `OFF_GLOBAL_CTRL) begin
			next_prdata[2:0] = global_ctrl;
		end else if (paddr == `OFF_MASK_A) begin
			next_prdata[`CONV_COUNT-1:0] = rail_ok_source_mask_a;
		end else if (paddr == `OFF_MASK_B) begin
			next_prdata[1:0] = rail_ok_source_mask_b;
		end else if (paddr == `OFF_SLEEP_MAP) begin
			next_prdata[`CONV_COUNT-1:0] = sleep_pin_converter_map;
		end else if (paddr == `OFF_EN1_MAP) begin
			next_prdata[`CONV_COUNT-1:0] = enable_one_converter_map;
		end else if (paddr == `OFF_EN2_MAP) begin
			next_prdata[`CONV_COUNT-1:0] = enable_two_converter_map;
		end else if (paddr == `OFF_STATUS) begin
			next_prdata[0]   = rail_ok;
			next_prdata[5:1] = source_ok;
			next_prdata[6]   = dual_phase;
		end else if (conv_hit && conv_sub == `SUB_CTRL) begin
			next_prdata[1:0] = converter_control_reg[conv_idx];
		end else if (conv_hit && conv_sub == `SUB_PRIMARY) begin
			next_prdata[7:0] = primary_voltage_reg[conv_idx];
		end else if (conv_hit && conv_sub == `SUB_SECONDARY) begin
			next_prdata[7:0] = secondary_voltage_reg[conv_idx];
		end else if (conv_hit) begin
			next_prdata[6:0] = ch_code[conv_idx*`CODE_W +: `CODE_W];
			next_prdata[7]   = ramping[conv_idx];
			next_prdata[8]   = ch_on[conv_idx];
			next_prdata[9]   = ch_range[conv_idx];
		end else begin
			next_err = 1'b1;
		end
	end

	// global registers; reset leaves only the first source unmasked
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_ctrl              <= `RST_GLOBAL;
			rail_ok_source_mask_a    <= `RST_MASK_A; // RULE_03
			rail_ok_source_mask_b    <= `RST_MASK_B;
			sleep_pin_converter_map  <= `RST_MAP;
			enable_one_converter_map <= `RST_MAP;
			enable_two_converter_map <= `RST_MAP;
		end else if (wr_access) begin
			if (paddr == `OFF_GLOBAL_CTRL)
				global_ctrl <= pwdata[2:0];
			else if (paddr == `OFF_MASK_A)
				rail_ok_source_mask_a <= pwdata[`CONV_COUNT-1:0];
			else if (paddr == `OFF_MASK_B)
				rail_ok_source_mask_b <= pwdata[1:0];
			else if (paddr == `OFF_SLEEP_MAP)
				sleep_pin_converter_map <= pwdata[`CONV_COUNT-1:0]; // RULE_11
			else if (paddr == `OFF_EN1_MAP)
				enable_one_converter_map <= pwdata[`CONV_COUNT-1:0]; // RULE_11
			else if (paddr == `OFF_EN2_MAP)
				enable_two_converter_map <= pwdata[`CONV_COUNT-1:0]; // RULE_11
		end
	end

	// one tick per 10 mV at the fixed slew
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt  <= {`STEP_CNT_W{1'b0}};
			step_tick <= 1'b0;
		end else if (step_cnt == `STEP_LAST) begin
			step_cnt  <= {`STEP_CNT_W{1'b0}};
			step_tick <= 1'b1; // RULE_09
		end else begin
			step_cnt  <= step_cnt + 1'b1;
			step_tick <= 1'b0;
		end
	end

	// phase strap is sampled after reset release, never inside the async branch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dual_phase       <= 1'b0;
			pair_phase_force <= 2'b00;
		end else begin
			dual_phase       <= dual_phase_otp; // RULE_16
			pair_phase_force <= global_ctrl[`FLD_PHASE_HI:`FLD_PHASE_LO]; // RULE_17
		end
	end

	genvar i;
	generate
		for (i = 0; i < `CONV_COUNT; i = i + 1) begin : g_conv
			wire src;
			wire pin_act;
			localparam [2:0] ch_idx = i;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					converter_control_reg[i] <= `RST_CTRL;
					primary_voltage_reg[i]   <= `RST_VOLT;
					secondary_voltage_reg[i] <= `RST_VOLT; // RULE_12
				end else if (wr_access && conv_hit && conv_idx == i) begin
					if (conv_sub == `SUB_CTRL)
						converter_control_reg[i] <= pwdata[1:0];
					else if (conv_sub == `SUB_PRIMARY)
						primary_voltage_reg[i] <= pwdata[7:0];
					else if (conv_sub == `SUB_SECONDARY)
						secondary_voltage_reg[i] <= pwdata[7:0];
				end
			end
			// in dual phase the second phase follows the pair's register set
			assign src = (i == 1) && dual_phase; // RULE_16
			assign pin_act = pin_selects(sleep_pin_converter_map, enable_one_converter_map,
				enable_two_converter_map, src ? 3'd0 : ch_idx,
				sleep_request_pin, enable_pin_one, enable_pin_two); // RULE_10 RULE_11
			dvs_channel #(
				.SLEW          (i < 3 ? 1 : 0)
			) u_ch (
				.pclk          (pclk),
				.presetn       (presetn),
				.step_tick     (step_tick),
				.enable        (src ? converter_control_reg[0][`BIT_CTRL_EN]
					: converter_control_reg[i][`BIT_CTRL_EN]),
				.roof_floor_en (src ? converter_control_reg[0][`BIT_CTRL_RF]
					: converter_control_reg[i][`BIT_CTRL_RF]),
				.pin_active    (pin_act),
				.primary       (src ? primary_voltage_reg[0] : primary_voltage_reg[i]),
				.secondary     (src ? secondary_voltage_reg[0] : secondary_voltage_reg[i]),
				.target        (ch_target[i*`CODE_W +: `CODE_W]),
				.present       (ch_code[i*`CODE_W +: `CODE_W]),
				.range_active  (ch_range[i]),
				.on            (ch_on[i]),
				.ramping       (ramping[i])
			);
		end
	endgenerate

	// converter-facing outputs re-registered at the top
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_target <= {(`CONV_COUNT*`CODE_W){1'b0}};
			conv_code   <= {(`CONV_COUNT*`CODE_W){1'b0}};
			conv_range  <= {`CONV_COUNT{1'b0}};
			conv_on     <= {`CONV_COUNT{1'b0}};
		end else begin
			conv_target <= ch_target;
			conv_code   <= ch_code;
			conv_range  <= ch_range; // RULE_14
			conv_on     <= ch_on; // RULE_13
		end
	end

	// masking disabled rails and the pair stays with software
	rail_ok_combiner u_rail (
		.pclk           (pclk),
		.presetn        (presetn),
		.vwin_ok        (vwin_ok),
		.ilim_ok        (ilim_ok),
		.ramping        (ramping), // RULE_04
		.mask           (rail_ok_source_mask_a), // RULE_03
		.dual_phase     (dual_phase), // RULE_06
		.current_only   (rail_ok_source_mask_b[`BIT_TYPE_SEL]), // RULE_02
		.compmode       (global_ctrl[`BIT_COMPMODE]), // RULE_05
		.adc_mask       (rail_ok_source_mask_b[`BIT_ADC_MASK]),
		.adc_current_ok (adc_current_ok),
		.source_ok      (source_ok),
		.rail_ok        (rail_ok)
	);
endmodule

// [test/smps_analog_model.sv]
`timescale 1ns/1ps
module smps_analog_model (
	input  wire logic [4:0] vbad,
	input  wire logic [4:0] ibad,
	input  wire logic       adc_bad,
	output logic      [4:0] vwin_ok,
	output logic      [4:0] ilim_ok,
	output logic            adc_current_ok
);
	// comparators only, no analog timing; faults are forced by the bench
	assign vwin_ok = ~vbad;
	assign ilim_ok = ~ibad;
	assign adc_current_ok = ~adc_bad;
endmodule

// [test/smps_powergood_dvs_control_assertions.sv]
`timescale 1ns/1ps
`include "smps_ctrl_defs.vh"
module smps_pg_checker (
	input wire logic                           pclk,
	input wire logic                           presetn,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pready,
	input wire logic                           pslverr,
	input wire logic [`CONV_COUNT-1:0]         vwin_ok,
	input wire logic [`CONV_COUNT-1:0]         ilim_ok,
	input wire logic                           adc_current_ok,
	input wire logic                           rail_ok,
	input wire logic [`CONV_COUNT*`CODE_W-1:0] conv_target,
	input wire logic [`CONV_COUNT*`CODE_W-1:0] conv_code,
	input wire logic [`CONV_COUNT-1:0]         conv_range,
	input wire logic [`CONV_COUNT-1:0]         conv_on
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rail_all_good: assert property ($past(presetn) && &vwin_ok && &ilim_ok && adc_current_ok
		|=> rail_ok) else $error("rail low with all sources good");
	a_zero_code_off: assert property ((conv_target[20:14] == 7'h00) [*3] |-> !conv_on[2])
		else $error("converter on with zero code");
	a_jump_no_slew: assert property ((conv_on[3] && $stable(conv_target[27:21])) [*3]
		|-> conv_code[27:21] == conv_target[27:21]) else $error("jump converter lagging");
	a_slew_one_step: assert property (conv_on[0] && $past(conv_on[0]) && $changed(conv_code[6:0])
		|-> conv_code[6:0] - $past(conv_code[6:0]) == 7'h01
		|| $past(conv_code[6:0]) - conv_code[6:0] == 7'h01) else $error("code moved by more than a step");
	a_range_frozen: assert property (conv_on[2] && $past(conv_on[2]) |-> $stable(conv_range[2]))
		else $error("range changed while on");
endmodule

bind smps_powergood_dvs_control smps_pg_checker u_chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .vwin_ok, .ilim_ok, .adc_current_ok, .rail_ok, .conv_target, .conv_code,
	.conv_range, .conv_on);

// [test/smps_powergood_dvs_control_tb_top.sv]
`timescale 1ns/1ps
`include "smps_ctrl_defs.vh"
module smps_powergood_dvs_control_tb_top;
	logic                           pclk = '0;
	logic                           presetn = '0;
	logic                           psel = '0;
	logic                           penable = '0;
	logic                           pwrite = '0;
	logic [`ADDR_W-1:0]             paddr = '0;
	logic [31:0]                    pwdata = '0;
	logic [31:0]                    prdata;
	logic                           pready;
	logic                           pslverr;
	logic [2:0]                     pins = '0;
	logic [4:0]                     vbad = '0;
	logic [4:0]                     ibad = '0;
	logic                           adc_bad = '0;
	logic                           otp = '0;
	logic [`CONV_COUNT-1:0]         vwin_ok;
	logic [`CONV_COUNT-1:0]         ilim_ok;
	logic                           adc_current_ok;
	logic                           rail_ok;
	logic [`CONV_COUNT*`CODE_W-1:0] conv_target;
	logic [`CONV_COUNT*`CODE_W-1:0] conv_code;
	logic [`CONV_COUNT-1:0]         conv_range;
	logic [`CONV_COUNT-1:0]         conv_on;
	logic [1:0]                     pair_phase_force;
	logic                           dual_phase;
	logic [31:0]                    rd;
	logic                           err;
	integer                         miscompares = 0;
	integer                         checks = 0;

	always #2 pclk = ~pclk;

	smps_powergood_dvs_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sleep_request_pin(pins[0]), .enable_pin_one(pins[1]),
		.enable_pin_two(pins[2]), .dual_phase_otp(otp), .vwin_ok, .ilim_ok, .adc_current_ok,
		.rail_ok, .conv_target, .conv_code, .conv_range, .conv_on, .pair_phase_force, .dual_phase);
	smps_analog_model model (.vbad, .ibad, .adc_bad, .vwin_ok, .ilim_ok, .adc_current_ok);

	task finish_test;
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// settle past the edge so outputs are never read in the launching step
	task w(input integer n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task rail(input logic [4:0] v, input logic [4:0] i, input logic exp);
		@(posedge pclk);
		vbad <= v;
		ibad <= i;
		w(3);
		chk(rail_ok, exp);
	endtask

	task t_regs;
		apb(1'h0, 12'h004, 32'h0);
		chk(rd, 32'h1E);
		apb(1'h0, 12'hFFC, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
	endtask

	task t_rail;
		rail(5'h00, 5'h00, 1'h1);
		rail(5'h04, 5'h00, 1'h1);
		apb(1'h1, 12'h004, 8'h1A);
		rail(5'h04, 5'h00, 1'h0);
		rail(5'h00, 5'h01, 1'h0);
		apb(1'h1, 12'h004, 8'h1F);
		rail(5'h04, 5'h01, 1'h1);
		apb(1'h1, 12'h004, 8'h1E);
		apb(1'h1, 12'h008, 8'h01);
		rail(5'h01, 5'h00, 1'h1);
		rail(5'h01, 5'h01, 1'h0);
		apb(1'h1, 12'h008, 8'h00);
		apb(1'h1, 12'h000, 8'h01);
		adc_bad <= 1'h1;
		rail(5'h00, 5'h00, 1'h0);
		apb(1'h1, 12'h008, 8'h02);
		rail(5'h00, 5'h00, 1'h1);
		apb(1'h1, 12'h008, 8'h00);
		apb(1'h1, 12'h000, 8'h00);
		adc_bad <= 1'h0;
	endtask

	task t_cmd;
		apb(1'h1, 12'h044, 8'h85);
		apb(1'h1, 12'h048, 8'h20);
		apb(1'h1, 12'h040, 8'h01);
		w(4);
		chk({conv_on[2], conv_range[2], conv_target[20:14]}, 9'h185);
		apb(1'h1, 12'h048, 8'hA0);
		w(4);
		chk(conv_target[20:14], 7'h20);
		apb(1'h1, 12'h044, 8'h05);
		w(4);
		chk(conv_range[2], 1'h1);
		apb(1'h1, 12'h048, 8'h80);
		w(4);
		chk({conv_on[2], conv_range[2]}, 2'h0);
		apb(1'h1, 12'h040, 8'h00);
	endtask

	task t_rf;
		logic [11:0] m [3] = '{12'h00C, 12'h010, 12'h018};
		apb(1'h1, 12'h044, 8'h11);
		apb(1'h1, 12'h048, 8'h22);
		apb(1'h1, 12'h040, 8'h03);
		for (int k = 0; k < 3; k++) begin
			apb(1'h1, m[k], 8'h04);
			w(4);
			chk(conv_target[20:14], 7'h22);
			@(posedge pclk);
			pins[k] <= 1'h1;
			w(4);
			chk(conv_target[20:14], 7'h11);
			@(posedge pclk);
			pins[k] <= 1'h0;
			apb(1'h1, m[k], 8'h00);
		end
		apb(1'h1, 12'h040, 8'h00);
	endtask

	task t_ramp;
		integer n;
		apb(1'h1, 12'h024, 8'h10);
		apb(1'h1, 12'h020, 8'h01);
		w(4);
		chk(conv_code[6:0], 7'h10);
		apb(1'h1, 12'h024, 8'h12);
		// window fault only after ramping is up, else a real dip is legal
		w(5);
		rail(5'h01, 5'h00, 1'h1);
		n = 0;
		while (conv_code[6:0] !== 7'h12 && n < 5000) begin
			w(1);
			n++;
		end
		chk(n >= 980 && n <= 2010, 1'h1);
		rail(5'h01, 5'h00, 1'h0);
		rail(5'h00, 5'h00, 1'h1);
		apb(1'h1, 12'h020, 8'h00);
	endtask

	// second phase follows the pair registers and never counts as a source
	task t_dual;
		@(posedge pclk);
		otp <= 1'h1;
		apb(1'h1, 12'h024, 8'h15);
		apb(1'h1, 12'h020, 8'h01);
		w(4);
		chk(dual_phase, 1'h1);
		chk({conv_on[1], conv_target[13:7]}, 8'h95);
		apb(1'h1, 12'h004, 8'h1C);
		rail(5'h02, 5'h00, 1'h1);
		rail(5'h01, 5'h00, 1'h0);
		apb(1'h1, 12'h004, 8'h1E);
		apb(1'h1, 12'h020, 8'h00);
		rail(5'h00, 5'h00, 1'h1);
		@(posedge pclk);
		otp <= 1'h0;
	endtask

	task t_misc;
		apb(1'h1, 12'h054, 8'h10);
		apb(1'h1, 12'h050, 8'h01);
		apb(1'h1, 12'h054, 8'h30);
		w(4);
		chk(conv_code[27:21], 7'h30);
		apb(1'h1, 12'h050, 8'h00);
		apb(1'h1, 12'h000, 8'h04);
		w(2);
		chk(pair_phase_force, 2'h2);
		chk(dual_phase, 1'h0);
		apb(1'h1, 12'h000, 8'h00);
	endtask

	initial begin
		#200000;
		miscompares++;
		finish_test;
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		w(2);
		t_regs;
		t_rail;
		t_cmd;
		t_rf;
		t_ramp;
		t_dual;
		t_misc;
		finish_test;
	end
endmodule
